// File: verilog/rvc_pkg.sv
// Constants for the redundancy status, alignment test and impedance
// calibration control register group.
// Assumes a 16-bit management register port on the register clock.
package rvc_pkg;
  // Register addresses
  localparam logic [15:0] RVC_ADDR_COMPOSITE = 16'h808D;
  localparam logic [15:0] RVC_ADDR_ALIGN = 16'h808E;
  localparam logic [15:0] RVC_ADDR_DIE3 = 16'h8090;
  localparam logic [15:0] RVC_ADDR_DIE2 = 16'h8091;
  localparam logic [15:0] RVC_ADDR_DIE1 = 16'h8092;
  localparam logic [15:0] RVC_ADDR_DIE0 = 16'h8093;
  localparam logic [15:0] RVC_ADDR_CAL = 16'h8098;
  // Reset values
  localparam logic [15:0] RVC_RST_COMPOSITE = 16'h0000;
  localparam logic [15:0] RVC_RST_ALIGN = 16'h0000;
  localparam logic [15:0] RVC_RST_CAL = 16'hBB20;
  localparam logic [15:0] RVC_RST_ZERO = 16'h0000;
  // Composite status fields
  localparam int RVC_BIT_IDLE = 15;
  localparam int RVC_BIT_PRIMARY_A = 14;
  localparam int RVC_BIT_RETIME = 13;
  // Calibration control fields, macro 1 base; macro 2 sits 4 bits lower
  localparam int RVC_BIT_M1_EN = 15;
  localparam int RVC_BIT_M1_CLK = 14;
  localparam int RVC_BIT_M1_CLR_N = 13;
  localparam int RVC_BIT_M1_LOCK = 12;
  localparam int RVC_MACRO_STRIDE = 4;
  localparam int RVC_BIT_RESERVED = 7;
  localparam int RVC_BIT_TERM_N = 6;
  localparam int RVC_BIT_DRV_EN = 5;
  // Writable bits of the calibration control register (bit 7 reserved)
  localparam logic [15:0] RVC_CAL_WMASK = 16'hFF60;
  // Bit value layout: pull-down bits 15..11, pull-up bits 10..6
  localparam int RVC_BV_PD_HI = 15;
  localparam int RVC_BV_PD_LO = 11;
  localparam int RVC_BV_PU_HI = 10;
  localparam int RVC_BV_PU_LO = 6;
  localparam int RVC_STRENGTH_W = 5;
  // Update clock pulses per half and per whole load sequence; strength reset value
  localparam logic [6:0] RVC_HALF_PULSES = 7'h20;
  localparam logic [6:0] RVC_ALL_PULSES = 7'h40;
  localparam logic [4:0] RVC_STRENGTH_RST = 5'h00;
endpackage

// File: verilog/rvc_cal_loader.sv
// Update-clock driven loader of one impedance calibration macro.
// Assumes enable, update clock, clear and lock come from register flops
// on the same clock, and bit values are stable during loading.
`timescale 1ns/10ps
`default_nettype none
module rvc_cal_loader
  import rvc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Macro controls
  input wire logic enable,
  input wire logic update_clock,
  input wire logic clear_n,
  input wire logic lock,
  input wire logic [15:0] bit_values,
  // Loaded strengths
  output logic [4:0] pulldown_r,
  output logic [4:0] pullup_r,
  output logic [6:0] pulse_cnt_r
);
  logic clk_prev_r;
  logic clk_rise;
  logic do_clear;
  logic do_pulse;
  logic [6:0] cnt_nxt;

  // Pulse decode; lock freezes the settings, clear needs enable high
  assign clk_rise = update_clock & ~clk_prev_r;
  assign do_clear = enable & ~clear_n & ~lock;
  assign do_pulse = clk_rise & enable & ~lock;
  assign cnt_nxt = (pulse_cnt_r == RVC_ALL_PULSES) ? pulse_cnt_r :
                   pulse_cnt_r + 7'h01;

  // Edge history of the update clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) clk_prev_r <= 1'b0;
    else clk_prev_r <= update_clock;
  end

  // Pulse counter and strength registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_cnt_r <= 7'h00;
      pulldown_r <= RVC_STRENGTH_RST;
      pullup_r <= RVC_STRENGTH_RST;
    end else if (do_clear) begin
      pulse_cnt_r <= 7'h00;
      pulldown_r <= RVC_STRENGTH_RST;
      pullup_r <= RVC_STRENGTH_RST;
    end else if (do_pulse) begin
      pulse_cnt_r <= cnt_nxt;
      if (cnt_nxt == RVC_HALF_PULSES)
        pulldown_r <= bit_values[RVC_BV_PD_HI:RVC_BV_PD_LO];
      if (cnt_nxt == RVC_ALL_PULSES &&
          pulse_cnt_r != RVC_ALL_PULSES)
        pullup_r <= bit_values[RVC_BV_PU_HI:RVC_BV_PU_LO];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_lock_freezes: assert property (
    lock |=> $stable(pulldown_r) && $stable(pullup_r))
    else $error("strengths changed while locked");
  a_pd_load: assert property (
    do_pulse && !do_clear && pulse_cnt_r == 7'h1F |=>
      pulldown_r == $past(bit_values[15:11]))
    else $error("pull-down bits not loaded at pulse 32");
  c_full_load: cover property (do_pulse && pulse_cnt_r == 7'h3F);
endmodule
`default_nettype wire

// File: verilog/rvc_regs.sv
// Redundancy composite status, comma alignment test and impedance
// calibration control registers with die identifier readback.
// Assumes a one-cycle read or write strobe from the management logic
// on mclk; strap pins are asynchronous and synchronised here.
//
// Summary of operation
// - Status bit 15 reads high when idle is requested by register or pin.
// - Status bit 14 is OR of primary-select bit and pin; high is lane A.
// - Status bit 13 is OR of retimer bit and retimer pin.
// - Alignment register upper byte: one disables comma alignment per lane.
// - Alignment register lower byte: one induces an alignment jog per lane.
// - 64-bit die identifier over four read-only words, top slice first.
// - Calibration bit 15 enables macro 1; resets to one.
// - Calibration bit 14 is macro 1 update clock; resets to zero.
// - Bit 13 is macro 1 active-low clear; needs enable high to act.
// - Bit 12 locks macro 1 settings; must be low while loading.
// - Bits 11 to 8 are the same four controls for macro 2.
// - Bit 6 low connects parallel input termination; high removes it.
// - Bit 5 high lets all parallel outputs switch; low stops them.
// - Calibration register resets to 0xBB20.
// - Status and alignment registers reset to zero.
// - Over 64 pulses macros load pull-down then pull-up strength bits.
`timescale 1ns/10ps
`default_nettype none
module rvc_regs
  import rvc_pkg::*;
#(
  parameter int LANES = 8,
  parameter int MACROS = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Management register port
  input wire logic [15:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata_r,
  output logic mgmt_ack_r,
  // Redundancy control register bits, same clock
  input wire logic ctl_idle,
  input wire logic ctl_primary_a,
  input wire logic ctl_retime,
  // Device input pins, asynchronous
  input wire logic pin_idle,
  input wire logic pin_primary_a,
  input wire logic pin_retime,
  // Die identifier fuses, static
  input wire logic [63:0] die_identifier,
  // Per-macro bit value registers, macro 1 in the low word
  input wire logic [16*MACROS-1:0] cal_bit_values,
  // Lane controls
  output logic [LANES-1:0] comma_align_disable_r,
  output logic [LANES-1:0] comma_align_jog_bits_r,
  // Calibration macro controls
  output logic [MACROS-1:0] cal_enable_r,
  output logic [MACROS-1:0] cal_update_clock_r,
  output logic [MACROS-1:0] cal_clear_n_r,
  output logic [MACROS-1:0] cal_lock_r,
  output logic [5*MACROS-1:0] cal_pulldown_r,
  output logic [5*MACROS-1:0] cal_pullup_r,
  // Parallel interface controls
  output logic term_enable_n_r,
  output logic driver_enable_r
);
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] align_r;
  logic [15:0] cal_r;
  logic [15:0] cal_nxt;
  logic [15:0] rdata_nxt;
  logic sel_status;
  logic sel_align;
  logic sel_die3;
  logic sel_die2;
  logic sel_die1;
  logic sel_die0;
  logic sel_cal;
  logic wr_align;
  logic wr_cal;

  // Two-stage synchroniser for the strap pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {pin_idle, pin_primary_a, pin_retime};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Composite status merge of control bits and pins
  always_comb begin
    status_nxt = RVC_RST_ZERO;
    status_nxt[RVC_BIT_IDLE] = ctl_idle | pin_sync_r[2];
    status_nxt[RVC_BIT_PRIMARY_A] = ctl_primary_a | pin_sync_r[1];
    status_nxt[RVC_BIT_RETIME] = ctl_retime | pin_sync_r[0];
  end

  // Address decode
  assign sel_status = (mgmt_addr == RVC_ADDR_COMPOSITE);
  assign sel_align = (mgmt_addr == RVC_ADDR_ALIGN);
  assign sel_die3 = (mgmt_addr == RVC_ADDR_DIE3);
  assign sel_die2 = (mgmt_addr == RVC_ADDR_DIE2);
  assign sel_die1 = (mgmt_addr == RVC_ADDR_DIE1);
  assign sel_die0 = (mgmt_addr == RVC_ADDR_DIE0);
  assign sel_cal = (mgmt_addr == RVC_ADDR_CAL);
  // Only the two writable registers take writes
  assign wr_align = mgmt_wr & sel_align;
  assign wr_cal = mgmt_wr & sel_cal;
  assign cal_nxt = mgmt_wdata & RVC_CAL_WMASK;

  // Read data select, unmapped addresses read zero
  assign rdata_nxt =
    sel_status ? status_r :
    sel_align ? align_r :
    sel_die3 ? die_identifier[63:48] :
    sel_die2 ? die_identifier[47:32] :
    sel_die1 ? die_identifier[31:16] :
    sel_die0 ? die_identifier[15:0] :
    sel_cal ? cal_r : RVC_RST_ZERO;

  // Status and alignment test registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r <= RVC_RST_COMPOSITE;
      align_r <= RVC_RST_ALIGN;
    end else begin
      status_r <= status_nxt;
      if (wr_align) align_r <= mgmt_wdata;
    end
  end

  // Calibration control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cal_r <= RVC_RST_CAL;
    else if (wr_cal) cal_r <= cal_nxt;
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mgmt_rdata_r <= RVC_RST_ZERO;
      mgmt_ack_r <= 1'b0;
    end else begin
      mgmt_ack_r <= mgmt_rd | mgmt_wr;
      if (mgmt_rd) mgmt_rdata_r <= rdata_nxt;
    end
  end

  // Lane controls and parallel interface controls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      comma_align_disable_r <= '0;
      comma_align_jog_bits_r <= '0;
      term_enable_n_r <= RVC_RST_CAL[RVC_BIT_TERM_N];
      driver_enable_r <= RVC_RST_CAL[RVC_BIT_DRV_EN];
    end else begin
      comma_align_disable_r <= align_r[8 +: LANES];
      comma_align_jog_bits_r <= align_r[0 +: LANES];
      term_enable_n_r <= cal_r[RVC_BIT_TERM_N];
      driver_enable_r <= cal_r[RVC_BIT_DRV_EN];
    end
  end

  // Per-macro control fan-out and strength loaders
  genvar m;
  generate
    for (m = 0; m < MACROS; m++) begin : g_macro
      localparam int B = RVC_BIT_M1_EN - m * RVC_MACRO_STRIDE;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cal_enable_r[m] <= RVC_RST_CAL[B];
          cal_update_clock_r[m] <= RVC_RST_CAL[B-1];
          cal_clear_n_r[m] <= RVC_RST_CAL[B-2];
          cal_lock_r[m] <= RVC_RST_CAL[B-3];
        end else begin
          cal_enable_r[m] <= cal_r[B];
          cal_update_clock_r[m] <= cal_r[B-1];
          cal_clear_n_r[m] <= cal_r[B-2];
          cal_lock_r[m] <= cal_r[B-3];
        end
      end
      rvc_cal_loader u_loader (
        .mclk(mclk),
        .rst(rst),
        .enable(cal_enable_r[m]),
        .update_clock(cal_update_clock_r[m]),
        .clear_n(cal_clear_n_r[m]),
        .lock(cal_lock_r[m]),
        .bit_values(cal_bit_values[16*m +: 16]),
        .pulldown_r(cal_pulldown_r[5*m +: 5]),
        .pullup_r(cal_pullup_r[5*m +: 5]),
        .pulse_cnt_r()
      );
    end
  endgenerate

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_idle_composite: assert property (
    ##3 ($past(ctl_idle) || $past(pin_sync_r[2])) |->
      status_r[RVC_BIT_IDLE])
    else $error("idle composite bit low while requested");
  a_primary_merge: assert property (
    status_r[RVC_BIT_PRIMARY_A] == $past(ctl_primary_a | pin_sync_r[1]))
    else $error("primary select composite wrong");
  a_retime_merge: assert property (
    $rose(pin_retime) ##1 pin_retime [*2] |=> status_r[RVC_BIT_RETIME])
    else $error("retime pin not reflected after sync");
  a_align_disable: assert property (
    wr_align |=> ##1 comma_align_disable_r == $past(mgmt_wdata[15:8], 2))
    else $error("comma alignment disable not applied");
  a_jog_apply: assert property (
    wr_align |=> ##1 comma_align_jog_bits_r == $past(mgmt_wdata[7:0], 2))
    else $error("jog bits not applied");
  a_die_order: assert property (
    mgmt_rd && sel_die3 |=> mgmt_ack_r &&
      mgmt_rdata_r == $past(die_identifier[63:48]))
    else $error("die identifier top slice misplaced");
  a_cal_reset: assert property (
    $fell(rst) |-> cal_r == RVC_RST_CAL && driver_enable_r)
    else $error("calibration control reset value wrong");
  a_ro_ignored: assert property (
    mgmt_wr && (sel_die0 || sel_status) |=> $stable(cal_r) &&
      $stable(align_r))
    else $error("read-only write disturbed a register");
  a_reserved_zero: assert property (
    !cal_r[RVC_BIT_RESERVED])
    else $error("reserved calibration bit set");
  a_macro2_map: assert property (
    wr_cal |=> ##1 cal_lock_r[1] == $past(mgmt_wdata[8], 2))
    else $error("macro 2 lock not mapped from bit 8");
  a_drv_enable: assert property (
    wr_cal |=> ##1 driver_enable_r == $past(mgmt_wdata[5], 2))
    else $error("driver enable not applied");
  // Pin paths through the synchroniser, the remaining status merge and reset values
  a_pin_idle: assert property (
    $rose(pin_idle) ##1 pin_idle [*2] |=> status_r[RVC_BIT_IDLE])
    else $error("idle pin not reflected after sync");
  a_pin_primary: assert property (
    $rose(pin_primary_a) ##1 pin_primary_a [*2] |=>
      status_r[RVC_BIT_PRIMARY_A])
    else $error("primary select pin not reflected after sync");
  a_retime_ctl: assert property (
    status_r[RVC_BIT_RETIME] == $past(ctl_retime | pin_sync_r[0]))
    else $error("retime composite wrong");
  a_status_reset: assert property (
    $fell(rst) |-> status_r == RVC_RST_COMPOSITE &&
      align_r == RVC_RST_ALIGN)
    else $error("status or alignment reset value wrong");
  // Die identifier slices below the top one
  a_die_slice2: assert property (
    mgmt_rd && sel_die2 |=> mgmt_rdata_r == $past(die_identifier[47:32]))
    else $error("die identifier slice 2 misplaced");
  a_die_slice1: assert property (
    mgmt_rd && sel_die1 |=> mgmt_rdata_r == $past(die_identifier[31:16]))
    else $error("die identifier slice 1 misplaced");
  a_die_slice0: assert property (
    mgmt_rd && sel_die0 |=> mgmt_rdata_r == $past(die_identifier[15:0]))
    else $error("die identifier slice 0 misplaced");
  // Field mapping of the calibration register onto the macro and termination controls
  a_m1_enable: assert property (
    wr_cal |=> ##1 cal_enable_r[0] == $past(mgmt_wdata[15], 2))
    else $error("macro 1 enable not mapped from bit 15");
  a_m1_uclk: assert property (
    wr_cal |=> ##1 cal_update_clock_r[0] == $past(mgmt_wdata[14], 2))
    else $error("macro 1 update clock not mapped from bit 14");
  a_m1_clear: assert property (
    wr_cal |=> ##1 cal_clear_n_r[0] == $past(mgmt_wdata[13], 2))
    else $error("macro 1 clear not mapped from bit 13");
  a_m1_lock: assert property (
    wr_cal |=> ##1 cal_lock_r[0] == $past(mgmt_wdata[12], 2))
    else $error("macro 1 lock not mapped from bit 12");
  a_m2_enable: assert property (
    wr_cal |=> ##1 cal_enable_r[1] == $past(mgmt_wdata[11], 2))
    else $error("macro 2 enable not mapped from bit 11");
  a_m2_uclk: assert property (
    wr_cal |=> ##1 cal_update_clock_r[1] == $past(mgmt_wdata[10], 2))
    else $error("macro 2 update clock not mapped from bit 10");
  a_m2_clear: assert property (
    wr_cal |=> ##1 cal_clear_n_r[1] == $past(mgmt_wdata[9], 2))
    else $error("macro 2 clear not mapped from bit 9");
  a_term_map: assert property (
    wr_cal |=> ##1 term_enable_n_r == $past(mgmt_wdata[6], 2))
    else $error("termination enable not mapped from bit 6");
  // Write path, hold and read-only checks
  a_cal_write: assert property (
    wr_cal |=> cal_r == {$past(mgmt_wdata[15:8]), 1'b0,
      $past(mgmt_wdata[6:5]), 5'h00})
    else $error("calibration write not masked");
  a_align_hold: assert property (
    !wr_align |=> $stable(align_r))
    else $error("alignment register changed without a write");
  a_cal_hold: assert property (
    !wr_cal |=> $stable(cal_r))
    else $error("calibration register changed without a write");
  a_ro_die_write: assert property (
    mgmt_wr && (sel_die3 || sel_die2 || sel_die1) |=> $stable(cal_r) &&
      $stable(align_r))
    else $error("die identifier write disturbed a register");
  c_unlock: cover property (wr_cal && mgmt_wdata == 16'hAA00);
  c_pulse: cover property (wr_cal && mgmt_wdata == 16'hEE00);
  c_relock: cover property (wr_cal && mgmt_wdata == 16'hBB20);
  c_die_read: cover property (mgmt_rd && sel_die0);
endmodule
`default_nettype wire

// File: verification/rvc_host.sv
// Management host model that drives the register strobe port.
// Assumes strobes are taken on the mclk rise and ack comes one cycle later.
`timescale 1ns/10ps
`default_nettype none
module rvc_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [15:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata_r,
  input wire logic mgmt_ack_r
);
  // Idle bus at time zero
  initial begin
    mgmt_addr = 16'h0000;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Strobe and address held until ack is seen, then released and scrambled
  task automatic xfer(input logic w, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    @(posedge mclk);
    mgmt_addr <= a;
    mgmt_wdata <= w ? d : ~d;
    mgmt_wr <= w;
    mgmt_rd <= !w;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk);
      if (mgmt_ack_r === 1'b1) begin
        ok = 1'b1;
        q = mgmt_rdata_r;
      end
    end
    mgmt_wr <= 1'b0;
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: verification/rvc_regs_tb.sv
// Self-checking bench for the status and calibration register group.
// Assumes the host model in rvc_host.sv and the design package.
`timescale 1ns/10ps
`default_nettype none
module rvc_regs_tb
  import rvc_pkg::*;
;
  localparam logic [63:0] DIE = 64'h0123_4567_89AB_CDEF;
  typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} rvc_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] src = 6'h00;
  logic [15:0] addr, wdata, rdata;
  logic wr_s, rd_s, ack;
  logic [7:0] dis, jog;
  logic [1:0] en, uclk, clrn, lock;
  logic [9:0] pd, pu;
  logic term_n, drv;
  int n_mismatch = 0;
  int cmp_count = 0;
  int i;
  logic [15:0] al_s, cal_s;
  rvc_row_t rows [10] = '{'{RVC_ADDR_ALIGN, 16'hA55A, 16'hA55A},
    '{RVC_ADDR_ALIGN, 16'h5AA5, 16'h5AA5}, '{RVC_ADDR_CAL, 16'hFFFF, 16'hFF60},
    '{RVC_ADDR_CAL, 16'h0000, 16'h0000}, '{RVC_ADDR_COMPOSITE, 16'hFFFF, 0},
    '{RVC_ADDR_DIE3, 16'hFFFF, DIE[63:48]}, '{RVC_ADDR_DIE2, 0, DIE[47:32]},
    '{RVC_ADDR_DIE1, 16'h1111, DIE[31:16]}, '{RVC_ADDR_DIE0, 0, DIE[15:0]},
    '{16'h8094, 16'hFFFF, 16'h0000}};
  // Clock
  always #12.5 mclk = ~mclk;
  rvc_host host_u (.mclk(mclk), .mgmt_addr(addr), .mgmt_wr(wr_s),
    .mgmt_rd(rd_s), .mgmt_wdata(wdata), .mgmt_rdata_r(rdata),
    .mgmt_ack_r(ack));
  rvc_regs #(.LANES(8), .MACROS(2)) dut_u (.mclk(mclk), .rst(rst),
    .mgmt_addr(addr), .mgmt_wr(wr_s), .mgmt_rd(rd_s), .mgmt_wdata(wdata),
    .mgmt_rdata_r(rdata), .mgmt_ack_r(ack), .ctl_idle(src[0]),
    .ctl_primary_a(src[1]), .ctl_retime(src[2]), .pin_idle(src[3]),
    .pin_primary_a(src[4]), .pin_retime(src[5]), .die_identifier(DIE),
    .cal_bit_values({16'h5F00, 16'hA0C0}), .comma_align_disable_r(dis),
    .comma_align_jog_bits_r(jog), .cal_enable_r(en),
    .cal_update_clock_r(uclk), .cal_clear_n_r(clrn), .cal_lock_r(lock),
    .cal_pulldown_r(pd), .cal_pullup_r(pu), .term_enable_n_r(term_n),
    .driver_enable_r(drv));
  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Bus cycle with timeout handling
  task automatic xf(input logic w, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q);
    logic ok;
    host_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH ack expected 1 seen 0");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    xf(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] e,
      input string s);
    logic [15:0] q;
    xf(1'b0, a, 16'h0000, q);
    check(s, e, q);
  endtask
  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask
  // Expected control outputs from a calibration register value
  function automatic logic [9:0] calo(input logic [15:0] r);
    return {r[11], r[15], r[10], r[14], r[9], r[13], r[8], r[12], r[6], r[5]};
  endfunction
  function automatic logic [9:0] ctl_seen();
    return {en, uclk, clrn, lock, term_n, drv};
  endfunction
  task automatic pulses(input int k);
    repeat (k) begin
      wr(RVC_ADDR_CAL, 16'hEE00);
      wr(RVC_ADDR_CAL, 16'hAA00);
    end
    settle();
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("rst ctl", calo(RVC_RST_CAL), ctl_seen());
    check("rst lanes", 0, {dis, jog});
    check("rst strengths", 0, {pd, pu});
    rchk(RVC_ADDR_CAL, RVC_RST_CAL, "cal");
    rchk(RVC_ADDR_ALIGN, RVC_RST_ALIGN, "align");
    rchk(RVC_ADDR_COMPOSITE, RVC_RST_COMPOSITE, "status");
    $display("Test reset done");
  endtask
  initial begin
    do_reset();
    al_s = RVC_RST_ALIGN;
    cal_s = RVC_RST_CAL;
    for (i = 0; i < 10; i++) begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == RVC_ADDR_ALIGN) al_s = rows[i].e;
      if (rows[i].a == RVC_ADDR_CAL) cal_s = rows[i].e;
      rchk(rows[i].a, rows[i].e, "row read");
      check("lanes", al_s, {dis, jog});
      check("cal ctl", calo(cal_s), ctl_seen());
    end
    $display("Test rows done");
    for (i = 0; i < 6; i++) begin
      src <= 6'h01 << i;
      repeat (4) @(posedge mclk);
      rchk(RVC_ADDR_COMPOSITE, 16'h8000 >> (i % 3), "status");
    end
    src <= 6'h00;
    $display("Test status done");
    wr(RVC_ADDR_CAL, 16'hAA00);
    wr(RVC_ADDR_CAL, 16'hCC00);
    wr(RVC_ADDR_CAL, 16'hAA00);
    pulses(31);
    check("pd 31", 0, pd);
    pulses(1);
    check("pd 32", {5'h0B, 5'h14}, pd);
    check("pu 32", 0, pu);
    pulses(32);
    check("pu 64", {5'h1C, 5'h03}, pu);
    pulses(1);
    check("pd sat", {5'h0B, 5'h14}, pd);
    wr(RVC_ADDR_CAL, 16'hDD00);
    settle();
    check("pd lock", {5'h0B, 5'h14}, pd);
    wr(RVC_ADDR_CAL, 16'h4400);
    settle();
    check("pu off", {5'h1C, 5'h03}, pu);
    wr(RVC_ADDR_CAL, 16'hCC00);
    settle();
    check("clear", 0, {pd, pu});
    wr(RVC_ADDR_CAL, 16'hBB20);
    rchk(RVC_ADDR_CAL, 16'hBB20, "cal end");
    $display("Test calibration done");
    do_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
